// file: design/erg_consts.svh
`ifndef ERG_CONSTS_SVH
`define ERG_CONSTS_SVH
// ------------------------------------------------------------
// Bus identifiers and command bytes
// ------------------------------------------------------------
`define ERG_ID_ARRAY   7'h50
`define ERG_ID_POT     7'h57
`define ERG_ID_CTRL    7'h52
`define ERG_CTRL_ADDR  8'hff
`define ERG_WEL_SET    8'h02
`define ERG_WEL_CLR    8'h00
`define ERG_REGISTER_WRITE_UNLOCK_SET   8'h06
`define ERG_POT_RSVD   2'h3
`define ERG_FILL_BYTE  8'hff
`define ERG_BYTE_BITS  4'h8
`define ERG_LAST_PHASE 2'h2
// ------------------------------------------------------------
// Control register bit positions and factory values
// ------------------------------------------------------------
`define ERG_B_DLY_LO   0
`define ERG_B_WEL      1
`define ERG_B_REGISTER_WRITE_UNLOCK     2
`define ERG_B_LOCK_LO  3
`define ERG_B_LOCK_HI  4
`define ERG_B_MON3     5
`define ERG_B_MON2     6
`define ERG_B_DLY_HI   7
`define ERG_LOCK_DEF   2'h0
`define ERG_DLY_DEF    2'h1
`define ERG_LOCK_QTR   8'hc0
`define ERG_LOCK_HALF  8'h80
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define ERG_CLK_KHZ    20000
`define ERG_DLY0_MS    50
`define ERG_DLY1_MS    100
`define ERG_DLY2_MS    200
`define ERG_DLY3_MS    300
`define ERG_DLY_W      23
`endif

// file: design/erg_pkg.sv
package erg_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_RXB   = 3'b001,
      ST_RXACK = 3'b010,
      ST_TXB   = 3'b011,
      ST_TXACK = 3'b100
   } erg_state_e;

   typedef enum logic [1:0] {
      ID_ARR  = 2'b00,
      ID_POT  = 2'b01,
      ID_CTRL = 2'b10
   } erg_id_e;

   typedef struct packed {
      logic [1:0]  scl_s;
      logic [1:0]  sda_s;
      logic [1:0]  wp_s;
      logic [1:0]  m2_s;
      logic [1:0]  m3_s;
      logic        scl_q;
      logic        sda_q;
      erg_state_e  st;
      erg_id_e     id;
      logic        rd;
      logic [1:0]  phase;
      logic [3:0]  bitc;
      logic [7:0]  sh;
      logic [7:0]  ptr;
      logic        cur_ok;
      logic        addr_set;
      logic        reg_done;
      logic        mack;
      logic        write_enable_latch;
      logic        register_write_unlock;
      logic [1:0]  lock;
      logic [1:0]  dly;
      logic        f2;
      logic        f3;
      logic        oe;
      logic        armed;
      logic [22:0] hold;
      logic        hold_on;
   } erg_s;
endpackage

// file: design/erg_top.sv
`timescale 1ns/1ns
`include "erg_consts.svh"
// How it works
// - Pointer advances by one after each read
// - Read address acked, eight bits sent
// - Other-identifier access blocks current reads
// - Dummy write loads the address pointer
// - Repeated start read returns addressed byte
// - Stop after address: load pointer, standby
// - Master ack fetches next byte
// - Pointer wraps from last byte to zero
// - Volatile bits clear; stored bits reload factory values
// - Writes nacked unless write enable set
// - 02h sets, 00h clears write enable
// - Enable change needs no programming wait
// - Other bits change only when unlocked, except monitor flags, which drop at a low level
// - Unlock settable only with write enable
// - Unlock clears on write or lock hit
// - Lock field selects protected address range
// - Write to locked address aborted
// - Nonzero lock refuses wiper writes
// - Protect pin blocks array/wiper writes
// - Power-on hold always uses the factory delay value, DLY1_CYC
// - Control register: address FFh, one byte
// - Control register bit layout fixed
module erg_top #(
   parameter int unsigned DLY0_CYC = `ERG_DLY0_MS * `ERG_CLK_KHZ,
   parameter int unsigned DLY1_CYC = `ERG_DLY1_MS * `ERG_CLK_KHZ,
   parameter int unsigned DLY2_CYC = `ERG_DLY2_MS * `ERG_CLK_KHZ,
   parameter int unsigned DLY3_CYC = `ERG_DLY3_MS * `ERG_CLK_KHZ,
   parameter int unsigned DEPTH    = 256
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Two-wire bus
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // Protection and monitor levels
   input  wire logic       wp_i,
   input  wire logic       monitor_two_level,
   input  wire logic       monitor_three_level,
   // Status
   output logic [7:0]      control_status_reg,
   output logic            supply_reset_out
);
   erg_pkg::erg_s r;
   erg_pkg::erg_s n;
   logic [7:0]    mem [DEPTH];
   logic          scl, sda, rise, fall, start, stop, locked, dec, mem_we;
   logic [7:0]    ctrl;

   // ------------------------------------------------------------
   // Line events
   // ------------------------------------------------------------
   assign scl   = r.scl_s[1];
   assign sda   = r.sda_s[1];
   assign rise  = scl & ~r.scl_q;
   assign fall  = ~scl & r.scl_q;
   assign start = scl & r.scl_q & r.sda_q & ~sda;
   assign stop  = scl & r.scl_q & ~r.sda_q & sda;
   assign dec   = (r.st == erg_pkg::ST_RXB) && fall && (r.bitc == `ERG_BYTE_BITS);

   // Control register image
   always_comb
   begin
      ctrl = '0;
      ctrl[`ERG_B_DLY_HI]  = r.dly[1];
      ctrl[`ERG_B_MON2]    = r.f2;
      ctrl[`ERG_B_MON3]    = r.f3;
      ctrl[`ERG_B_LOCK_HI] = r.lock[1];
      ctrl[`ERG_B_LOCK_LO] = r.lock[0];
      ctrl[`ERG_B_REGISTER_WRITE_UNLOCK]    = r.register_write_unlock;
      ctrl[`ERG_B_WEL]     = r.write_enable_latch;
      ctrl[`ERG_B_DLY_LO]  = r.dly[0];
   end

   // Protected range of the pointer
   always_comb
   begin
      case (r.lock)
         2'h0:    locked = 1'b0;
         2'h1:    locked = r.ptr >= `ERG_LOCK_QTR;
         2'h2:    locked = r.ptr >= `ERG_LOCK_HALF;
         default: locked = 1'b1;
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic ack;
      logic load;
      logic [7:0] tx;
      ack  = 1'b0;
      load = 1'b0;
      tx   = `ERG_FILL_BYTE;
      n    = r;
      mem_we = 1'b0;
      n.scl_s = {r.scl_s[0], scl_i};
      n.sda_s = {r.sda_s[0], sda_i};
      n.wp_s  = {r.wp_s[0], wp_i};
      n.m2_s  = {r.m2_s[0], monitor_two_level};
      n.m3_s  = {r.m3_s[0], monitor_three_level};
      n.scl_q = scl;
      n.sda_q = sda;
      n.f2    = r.f2 & r.m2_s[1];
      n.f3    = r.f3 & r.m3_s[1];
      case (r.st)
         erg_pkg::ST_RXB:
         begin
            if (rise)
            begin
               n.sh   = {r.sh[6:0], sda};
               n.bitc = r.bitc + 4'h1;
            end
            if (dec)
            begin
               n.bitc = '0;
               case (r.phase)
                  2'h0:
                  begin
                     n.rd = r.sh[0];
                     if (r.sh[7:1] == `ERG_ID_ARRAY)
                     begin
                        n.id = erg_pkg::ID_ARR;
                        ack  = ~r.sh[0] | r.cur_ok | r.addr_set;
                     end
                     else if (r.sh[7:1] == `ERG_ID_POT || r.sh[7:1] == `ERG_ID_CTRL)
                     begin
                        n.id = (r.sh[7:1] == `ERG_ID_POT) ? erg_pkg::ID_POT
                                                           : erg_pkg::ID_CTRL;
                        n.cur_ok = 1'b0;
                        ack = 1'b1;
                     end
                  end
                  2'h1:
                  begin
                     if (r.id == erg_pkg::ID_ARR)
                     begin
                        n.ptr = r.sh;
                        n.addr_set = 1'b1;
                        ack = 1'b1;
                     end
                     else if (r.id == erg_pkg::ID_POT)
                        ack = r.sh[1:0] != `ERG_POT_RSVD;
                     else
                        ack = r.sh == `ERG_CTRL_ADDR;
                  end
                  default:
                  begin
                     if (r.id == erg_pkg::ID_ARR)
                     begin
                        if (locked)
                           n.register_write_unlock = 1'b0;
                        ack = r.write_enable_latch & ~r.wp_s[1] & ~locked;
                        mem_we = ack;
                        if (ack)
                           n.ptr = r.ptr + 8'h1;
                     end
                     else if (r.id == erg_pkg::ID_POT)
                        ack = r.write_enable_latch & (r.lock == `ERG_LOCK_DEF) & ~r.wp_s[1];
                     else if (!r.reg_done)
                     begin
                        n.reg_done = 1'b1;
                        if (r.register_write_unlock && !r.sh[`ERG_B_REGISTER_WRITE_UNLOCK])
                        begin
                           ack    = 1'b1;
                           n.write_enable_latch  = r.sh[`ERG_B_WEL];
                           n.register_write_unlock = 1'b0;
                           n.f2   = r.sh[`ERG_B_MON2] & r.m2_s[1];
                           n.f3   = r.sh[`ERG_B_MON3] & r.m3_s[1];
                           if (!r.wp_s[1])
                           begin
                              n.lock = {r.sh[`ERG_B_LOCK_HI], r.sh[`ERG_B_LOCK_LO]};
                              n.dly  = {r.sh[`ERG_B_DLY_HI], r.sh[`ERG_B_DLY_LO]};
                           end
                        end
                        else if (r.register_write_unlock)
                           ack = 1'b1;
                        else if (r.sh == `ERG_WEL_SET || r.sh == `ERG_WEL_CLR)
                        begin
                           ack   = 1'b1;
                           n.write_enable_latch = r.sh == `ERG_WEL_SET;
                        end
                        else if (r.sh == `ERG_REGISTER_WRITE_UNLOCK_SET)
                        begin
                           ack    = r.write_enable_latch;
                           n.register_write_unlock = r.write_enable_latch;
                        end
                     end
                  end
               endcase
               if (r.phase != `ERG_LAST_PHASE)
                  n.phase = r.phase + 2'h1;
               n.oe = ack;
               n.st = ack ? erg_pkg::ST_RXACK : erg_pkg::ST_IDLE;
            end
         end
         erg_pkg::ST_RXACK:
            if (fall)
            begin
               n.oe = 1'b0;
               n.st = erg_pkg::ST_RXB;
               load = r.rd && (r.phase == 2'h1);
            end
         erg_pkg::ST_TXB:
         begin
            if (rise)
               n.bitc = r.bitc + 4'h1;
            if (fall)
            begin
               if (r.bitc == `ERG_BYTE_BITS)
               begin
                  n.oe   = 1'b0;
                  n.bitc = '0;
                  n.st   = erg_pkg::ST_TXACK;
               end
               else
               begin
                  n.sh = {r.sh[6:0], 1'b0};
                  n.oe = ~r.sh[6];
               end
            end
         end
         erg_pkg::ST_TXACK:
         begin
            if (rise)
               n.mack = ~sda;
            if (fall)
            begin
               n.st = erg_pkg::ST_IDLE;
               load = r.mack && (r.id == erg_pkg::ID_ARR);
            end
         end
         default: n.st = erg_pkg::ST_IDLE;
      endcase
      // Fetch a byte for transmission
      if (load)
      begin
         if (r.id == erg_pkg::ID_ARR)
         begin
            tx    = mem[r.ptr];
            n.ptr = r.ptr + 8'h1;
            if (r.addr_set)
               n.cur_ok = 1'b1;
         end
         else if (r.id == erg_pkg::ID_CTRL)
            tx = ctrl;
         n.sh   = tx;
         n.oe   = ~tx[7];
         n.bitc = '0;
         n.st   = erg_pkg::ST_TXB;
      end
      // Start and stop override everything on the bus side
      if (start)
      begin
         n.st = erg_pkg::ST_RXB;
         n.phase = '0;
         n.bitc = '0;
         n.oe = 1'b0;
         n.reg_done = 1'b0;
      end
      else if (stop)
      begin
         n.st = erg_pkg::ST_IDLE;
         n.oe = 1'b0;
         n.addr_set = 1'b0;
         n.reg_done = 1'b0;
      end
      // Power-on hold timer
      if (r.armed)
      begin
         n.armed = 1'b0;
         case (r.dly)
            2'h0:    n.hold = `ERG_DLY_W'(DLY0_CYC);
            2'h1:    n.hold = `ERG_DLY_W'(DLY1_CYC);
            2'h2:    n.hold = `ERG_DLY_W'(DLY2_CYC);
            default: n.hold = `ERG_DLY_W'(DLY3_CYC);
         endcase
      end
      else if (r.hold != '0)
         n.hold = r.hold - `ERG_DLY_W'(1);
      n.hold_on = n.armed | (n.hold != '0);
      // Power-up: volatile bits zero, stored bits factory values
      if (!rst_n)
      begin
         n       = '0;
         n.scl_s = 2'h3;
         n.sda_s = 2'h3;
         n.scl_q = 1'b1;
         n.sda_q = 1'b1;
         n.lock  = `ERG_LOCK_DEF;
         n.dly   = `ERG_DLY_DEF;
         n.armed = 1'b1;
         n.hold_on = 1'b1;
         mem_we  = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk)
      r <= n;

   // Array storage, no reset
   always_ff @(posedge clk)
      if (mem_we)
         mem[r.ptr] <= r.sh;

   // Outputs
   assign sda_o              = 1'b0;
   assign sda_oe             = r.oe;
   assign control_status_reg = ctrl;
   assign supply_reset_out   = r.hold_on;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_arr_data;
      dec && r.phase == `ERG_LAST_PHASE && r.id == erg_pkg::ID_ARR;
   endsequence
   sequence s_tx_load;
      r.st != erg_pkg::ST_TXB && n.st == erg_pkg::ST_TXB && r.id == erg_pkg::ID_ARR;
   endsequence
   property p_ptr_inc;
      @(posedge clk) disable iff (!rst_n) s_tx_load |=> r.ptr == $past(r.ptr) + 8'h1;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");
   property p_no_wel;
      @(posedge clk) disable iff (!rst_n) s_arr_data and !r.write_enable_latch |=> r.st == erg_pkg::ST_IDLE && !r.oe;
   endproperty
   a_no_wel: assert property (p_no_wel) else $error("write acked without enable");
   property p_lock_hit;
      @(posedge clk) disable iff (!rst_n) s_arr_data and locked |=> !r.register_write_unlock && !r.oe;
   endproperty
   a_lock_hit: assert property (p_lock_hit) else $error("locked write not aborted");
   property p_wp;
      @(posedge clk) disable iff (!rst_n) s_arr_data and r.wp_s[1] |=> !r.oe;
   endproperty
   a_wp: assert property (p_wp) else $error("protected write acked");
   property p_register_write_unlock;
      @(posedge clk) disable iff (!rst_n) $rose(r.register_write_unlock) |-> $past(r.write_enable_latch);
   endproperty
   a_register_write_unlock: assert property (p_register_write_unlock) else $error("unlock set without enable");
   property p_lock_chg;
      @(posedge clk) disable iff (!rst_n) $changed(r.lock) |-> $past(r.register_write_unlock) && !r.register_write_unlock;
   endproperty
   a_lock_chg: assert property (p_lock_chg) else $error("lock changed while locked");
   property p_cur_blk;
      @(posedge clk) disable iff (!rst_n)
         dec && r.phase == 2'h0 && r.sh == {`ERG_ID_ARRAY, 1'b1} && !r.cur_ok && !r.addr_set
         |=> r.st == erg_pkg::ST_IDLE;
   endproperty
   a_cur_blk: assert property (p_cur_blk) else $error("current read not blocked");
   property p_ack_rel;
      @(posedge clk) disable iff (!rst_n) r.st == erg_pkg::ST_TXACK |-> !sda_oe;
   endproperty
   a_ack_rel: assert property (p_ack_rel) else $error("line held in ack clock");
   property p_stop;
      @(posedge clk) disable iff (!rst_n) stop |=> r.st == erg_pkg::ST_IDLE ##1 !sda_oe;
   endproperty
   a_stop: assert property (p_stop) else $error("no standby after stop");
   property p_hold;
      @(posedge clk) disable iff (!rst_n) $rose(rst_n) |-> supply_reset_out [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("power-on hold too short");
endmodule

// file: tb/erg_bus_master.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Two-wire bus master model
// ------------------------------------------------------------
module erg_bus_master (
   // Clock
   input  wire logic clk,
   // Bus lines
   output logic      scl,
   output logic      sda_m,
   input  wire logic sda
);
   // Lines idle high
   initial
   begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   // One bus phase, four clocks long
   task automatic step(input logic c, input logic b);
      scl   <= c;
      sda_m <= b;
      repeat (4) @(posedge clk);
   endtask

   // Start or repeated start: data falls while clock is high
   task automatic start();
      step(scl, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask

   // Stop: data rises while clock is high
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask

   // One bit; the line is sampled in the middle of the high phase
   task automatic bit_x(input logic b, output logic r);
      step(1'b0, b);
      step(1'b1, b);
      r = sda;
      step(1'b1, b);
      step(1'b0, b);
   endtask

   // Byte out, MSB first; line released in the ninth clock for the ack
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   // Byte in; the ninth clock carries ack or a high line to end the read
   task automatic rbyte(input logic mack, output logic [7:0] d, output logic rel);
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, d[i]);
      bit_x(~mack, rel);
   endtask
endmodule

// file: tb/test_eeprom_read_and_write_guard.sv
`timescale 1ns/1ns
`include "erg_consts.svh"
// ------------------------------------------------------------
// Bench for the read and write guard
// ------------------------------------------------------------
module test_eeprom_read_and_write_guard;
   logic        clk;
   logic        rst_n;
   logic        wp;
   logic        mon2;
   logic        mon3;
   logic        sda_oe;
   logic        scl;
   logic        sda_m;
   logic [7:0]  csr;
   logic        por;
   wire         sda;
   int          err_total;
   int          checks;
   logic [31:0] seed;
   logic [7:0]  mem [256];
   logic        a1, a2, a3;
   logic [7:0]  d;
   logic        rel;

   // Open-drain data line with pull-up
   assign sda = sda_m & ~sda_oe;

   // Clock, 50 ns period
   initial clk = 1'b0;
   always #25 clk = ~clk;

   erg_top #(.DLY0_CYC(20), .DLY1_CYC(40), .DLY2_CYC(80), .DLY3_CYC(120), .DEPTH(256)) DUT (
      .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
      .wp_i(wp), .monitor_two_level(mon2), .monitor_three_level(mon3),
      .control_status_reg(csr), .supply_reset_out(por));
   erg_bus_master ms (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));

   // Next pseudo-random word
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Compare and count
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Counts and verdict, then end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Three-byte write; a1..a3 hold the acks
   task automatic wr(input logic [6:0] id, input logic [7:0] adr, input logic [7:0] dat);
      ms.start();
      ms.wbyte({id, 1'b0}, a1);
      ms.wbyte(adr, a2);
      ms.wbyte(dat, a3);
      ms.stop();
   endtask

   // Array write; shadow copy follows an acked data byte
   task automatic awr(input logic [7:0] adr, input logic [7:0] dat, input logic exp);
      wr(`ERG_ID_ARRAY, adr, dat);
      if (a3 === 1'b1)
         mem[adr] = dat;
      chk("write ack", {7'h0, a3}, {7'h0, exp});
   endtask

   // Random read of n bytes checked against the shadow copy
   task automatic rrd(input logic [7:0] adr, input int n);
      ms.start();
      ms.wbyte({`ERG_ID_ARRAY, 1'b0}, a1);
      ms.wbyte(adr, a2);
      ms.start();
      ms.wbyte({`ERG_ID_ARRAY, 1'b1}, a3);
      chk("read acks", {5'h0, a1, a2, a3}, 8'h07);
      for (int i = 0; i < n; i++)
      begin
         ms.rbyte(i < n - 1, d, rel);
         chk("read data", d, mem[8'(adr + i)]);
      end
      chk("ack clock line", {7'h0, rel}, 8'h01);
      ms.stop();
   endtask

   // Current-address read, served or refused as ok says
   task automatic crd(input logic [7:0] adr, input logic ok);
      ms.start();
      ms.wbyte({`ERG_ID_ARRAY, 1'b1}, a1);
      chk("current ack", {7'h0, a1}, {7'h0, ok});
      if (a1 === 1'b1)
      begin
         ms.rbyte(1'b0, d, rel);
         chk("current data", d, mem[adr]);
      end
      ms.stop();
   endtask

   // Main sequence
   initial
   begin
      seed = 32'h00002944;
      err_total = 0;
      checks = 0;
      rst_n = 1'b0;
      wp = 1'b0;
      mon2 = 1'b0;
      mon3 = 1'b0;
      repeat (5) @(posedge clk);
      chk("reset status", csr, 8'h01);
      chk("reset hold", {7'h0, por}, 8'h01);
      rst_n <= 1'b1;
      repeat (35) @(posedge clk);
      chk("hold early", {7'h0, por}, 8'h01);
      repeat (10) @(posedge clk);
      chk("hold end", {7'h0, por}, 8'h00);
      $display("test reset done");
      // Writes and unlock refused without the enable latch
      awr(8'h10, 8'h5a, 1'b0);
      wr(`ERG_ID_CTRL, `ERG_CTRL_ADDR, `ERG_REGISTER_WRITE_UNLOCK_SET);
      chk("unlock refused", csr, 8'h01);
      wr(`ERG_ID_CTRL, `ERG_CTRL_ADDR, `ERG_WEL_SET);
      chk("latch set", csr, 8'h03);
      // Corner and random array writes, then reads across the wrap
      awr(8'hff, 8'h3c, 1'b1);
      awr(8'h00, 8'hc3, 1'b1);
      awr(8'h01, 8'h96, 1'b1);
      awr(8'hc5, 8'h77, 1'b1);
      for (int i = 0; i < 6; i++)
         awr(8'(rnd()), 8'(rnd()), 1'b1);
      rrd(8'hff, 2);
      crd(8'h01, 1'b1);
      ms.start();
      ms.wbyte({`ERG_ID_ARRAY, 1'b0}, a1);
      ms.wbyte(8'hc5, a2);
      ms.stop();
      crd(8'hc5, 1'b1);
      $display("test array reads done");
      // Register access blocks current reads until a random read
      wr(`ERG_ID_CTRL, `ERG_CTRL_ADDR, `ERG_REGISTER_WRITE_UNLOCK_SET);
      chk("unlock set", csr, 8'h07);
      wr(`ERG_ID_POT, 8'h00, 8'h20);
      chk("wiper open acks", {6'h0, a2, a3}, 8'h03);
      crd(8'h00, 1'b0);
      rrd(8'h00, 1);
      crd(8'h01, 1'b1);
      // Full register write locks the upper quarter and sets both monitor flags
      mon2 <= 1'b1;
      mon3 <= 1'b1;
      wr(`ERG_ID_CTRL, `ERG_CTRL_ADDR, 8'h6a);
      chk("full write", csr, 8'h6a);
      // Register read back through a dummy write and repeated start
      ms.start();
      ms.wbyte({`ERG_ID_CTRL, 1'b0}, a1);
      ms.wbyte(`ERG_CTRL_ADDR, a2);
      ms.start();
      ms.wbyte({`ERG_ID_CTRL, 1'b1}, a3);
      ms.rbyte(1'b0, d, rel);
      ms.stop();
      chk("register read acks", {5'h0, a1, a2, a3}, 8'h07);
      chk("register read", d, 8'h6a);
      // A low monitor level drops its flag
      mon3 <= 1'b0;
      repeat (4) @(posedge clk);
      chk("monitor flag drop", csr, 8'h4a);
      wr(`ERG_ID_CTRL, `ERG_CTRL_ADDR, `ERG_REGISTER_WRITE_UNLOCK_SET);
      awr(8'hc5, 8'h11, 1'b0);
      chk("unlock after lock hit", csr, 8'h4a);
      rrd(8'hc5, 1);
      awr(8'hbf, 8'h22, 1'b1);
      wr(`ERG_ID_POT, 8'h00, 8'h20);
      chk("wiper acks", {6'h0, a2, a3}, 8'h02);
      // Protect pin blocks an otherwise open address
      wp <= 1'b1;
      repeat (4) @(posedge clk);
      awr(8'h20, 8'h33, 1'b0);
      wp <= 1'b0;
      $display("test protection done");
      // Second register byte refused; first one clears the latch
      ms.start();
      ms.wbyte({`ERG_ID_CTRL, 1'b0}, a1);
      ms.wbyte(`ERG_CTRL_ADDR, a2);
      ms.wbyte(`ERG_WEL_CLR, a1);
      ms.wbyte(`ERG_WEL_CLR, a2);
      ms.stop();
      chk("second byte", {6'h0, a1, a2}, 8'h02);
      chk("latch cleared", csr, 8'h48);
      awr(8'h20, 8'h33, 1'b0);
      // Mid-run reset restores power-up values
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk("second reset", csr, 8'h01);
      chk("second reset hold", {7'h0, por}, 8'h01);
      repeat (35) @(posedge clk);
      chk("second hold early", {7'h0, por}, 8'h01);
      repeat (10) @(posedge clk);
      chk("second hold end", {7'h0, por}, 8'h00);
      $display("test registers done");
      stop_test();
   end

   // Watchdog against a hung bus
   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule
